// ==== design/rdd_rx_dma.sv ====
// Receive descriptor DMA channel with frame result byte
`timescale 1ns/1ps
`default_nettype none
`include "rdd_cfg.svh"
module rdd_rx_dma #(
  parameter int AW = 32,
  parameter int NW = 13
) (
  input  wire logic             CORE_CLK,
  input  wire logic             ARST_N,
  input  wire logic             CE,
  input  wire logic             CMD_REINIT,
  input  wire logic             CMD_RX_RESET,
  input  wire logic             CHAIN_SEL,
  input  wire logic [AW-1:0]    START_PTR,
  input  wire logic [AW-1:0]    LAST_PTR,
  input  wire logic             LAST_PTR_WR,
  output var  logic             MEM_REQ,
  output var  logic             MEM_WE,
  output var  logic [AW-1:0]    MEM_ADDR,
  output var  logic [31:0]      MEM_WDATA,
  output var  logic [3:0]       MEM_BE,
  input  wire logic             MEM_ACK,
  input  wire logic [31:0]      MEM_RDATA,
  input  wire logic             RXF_VALID,
  input  wire logic [31:0]      RXF_DATA,
  input  wire logic [2:0]       RXF_NBYTES,
  input  wire logic             RXF_LAST,
  output var  logic             RXF_READY,
  output var  logic             IRQ_VALID,
  output var  logic             IRQ_HI,
  output var  logic             IRQ_FI,
  output var  logic             IRQ_ERR,
  output var  logic             RX_ACTIVE,
  output var  logic [AW-1:0]    CUR_DESC_PTR,
  input  wire logic             FR_EOF,
  input  wire logic [13:0]      FR_LEN,
  input  wire logic             FR_BITS_OK,
  input  wire logic             FR_OVF,
  input  wire logic             FR_CRC_OK,
  input  wire logic             FR_RAB,
  input  wire logic             FR_CR,
  input  wire logic [7:0]       FR_HADDR,
  input  wire logic [7:0]       FR_LADDR,
  input  wire rdd_pkg::rdd_amode_t ADDR_MODE,
  input  wire logic             AUTO_ADDR_SEL,
  input  wire logic             CRC32_SEL,
  input  wire logic             CRC_KEEP_SEL,
  input  wire logic [7:0]       HIGH_ADDR_ONE,
  input  wire logic [7:0]       HIGH_ADDR_TWO,
  input  wire logic [7:0]       LOW_ADDR_ONE,
  input  wire logic [7:0]       LOW_ADDR_TWO,
  output var  logic [7:0]       FRAME_RESULT_BYTE,
  output var  logic             FRAME_RESULT_VALID
);
  import rdd_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [AW-1:0] word_addr(input logic [AW-1:0] b,
      input logic [2:0] i);
    word_addr = b + (AW'(i) << `RDD_WORD_SHIFT);
  endfunction

  function automatic logic [3:0] lane_en(input logic [2:0] n);
    case (n)
      3'h1:    lane_en = 4'h1;
      3'h2:    lane_en = 4'h3;
      3'h3:    lane_en = 4'h7;
      default: lane_en = `RDD_BE_ALL;
    endcase
  endfunction

  function automatic logic [31:0] stat_word(input logic fe,
      input logic ab, input logic [NW-1:0] stored_byte_count);
    stat_word = '0;
    stat_word[`RDD_FE_BIT] = fe;
    stat_word[`RDD_C_BIT] = 1'b1;
    stat_word[`RDD_NO_MSB:`RDD_NO_LSB] = stored_byte_count;
    stat_word[`RDD_RA_BIT] = ab;
  endfunction

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  rdd_link_if lnk ();

  rdd_desc_mem #(
    .DEPTH (`RDD_DESC_WORDS)
  ) u_mem (
    .clk   (CORE_CLK),
    .rst_n (ARST_N),
    .ce    (CE),
    .lnk   (lnk.dmem)
  );

  rdd_frame_stat u_stat (
    .clk   (CORE_CLK),
    .rst_n (ARST_N),
    .ce    (CE),
    .lnk   (lnk.stat)
  );

  assign lnk.fr_eof     = FR_EOF;
  assign lnk.fr_len     = FR_LEN;
  assign lnk.fr_bits_ok = FR_BITS_OK;
  assign lnk.fr_ovf     = FR_OVF;
  assign lnk.fr_crc_ok  = FR_CRC_OK;
  assign lnk.fr_rab     = FR_RAB;
  assign lnk.fr_cr      = FR_CR;
  assign lnk.fr_haddr   = FR_HADDR;
  assign lnk.fr_laddr   = FR_LADDR;
  assign lnk.h1         = HIGH_ADDR_ONE;
  assign lnk.h2         = HIGH_ADDR_TWO;
  assign lnk.l1         = LOW_ADDR_ONE;
  assign lnk.l2         = LOW_ADDR_TWO;
  assign lnk.amode      = ADDR_MODE;
  assign lnk.auto_sel   = AUTO_ADDR_SEL;
  assign lnk.crc32      = CRC32_SEL;
  assign lnk.keep       = CRC_KEEP_SEL;

  // ----------------------------------------------------------------
  // Channel state
  // ----------------------------------------------------------------
  rdd_state_t    state_q;
  logic [2:0]    widx_q;
  logic          hold_q;
  logic          hi_q;
  logic [NW-1:0] size_q;
  logic [NW-1:0] cnt_q;
  logic [2:0]    nb_q;
  logic          last_q;
  logic [AW-1:0] dptr_q;
  logic [AW-1:0] first_addr_q;
  logic          first_q;
  logic          fe_q;
  logic          abort_q;
  logic          rstp_q;
  logic          stop;
  logic          take;
  logic          in_desc;

  // Store writes come straight from the fetch answers
  assign lnk.dm_we    = CE && state_q == RDD_FETCH && MEM_REQ && MEM_ACK;
  assign lnk.dm_waddr = widx_q;
  assign lnk.dm_wdata = MEM_RDATA;

  always_comb begin
    case (state_q)
      RDD_LOADA: lnk.dm_raddr = `RDD_W_CTRL;
      RDD_LOADB: lnk.dm_raddr = `RDD_W_DATA;
      default:   lnk.dm_raddr = `RDD_W_NEXT;
    endcase
  end

  assign stop = CHAIN_SEL ? (CUR_DESC_PTR == LAST_PTR) : hold_q;
  assign take = state_q == RDD_FILL && RXF_READY && RXF_VALID &&
                !rstp_q && !CMD_RX_RESET;
  assign in_desc = state_q inside {RDD_LOADA, RDD_LOADB, RDD_LOADC,
                                   RDD_FILL, RDD_WDATA};

  // ----------------------------------------------------------------
  // Receiver reset capture
  // ----------------------------------------------------------------
  // Set only inside a descriptor: a reset arriving in RDD_BRNCH, as the old one is consumed, is dropped
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rstp_q <= 1'b0;
    end else if (CE) begin
      if (CMD_RX_RESET && in_desc) begin
        rstp_q <= 1'b1;
      end else if (state_q == RDD_BRNCH) begin
        rstp_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Descriptor sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q      <= RDD_IDLE;
      widx_q       <= '0;
      hold_q       <= 1'b0;
      hi_q         <= 1'b0;
      size_q       <= '0;
      cnt_q        <= '0;
      nb_q         <= '0;
      last_q       <= 1'b0;
      dptr_q       <= '0;
      first_addr_q <= '0;
      first_q      <= 1'b1;
      fe_q         <= 1'b0;
      abort_q      <= 1'b0;
      CUR_DESC_PTR <= '0;
      MEM_REQ      <= 1'b0;
      MEM_WE       <= 1'b0;
      MEM_ADDR     <= '0;
      MEM_WDATA    <= '0;
      MEM_BE       <= '0;
      RXF_READY    <= 1'b0;
      IRQ_VALID    <= 1'b0;
      IRQ_HI       <= 1'b0;
      IRQ_FI       <= 1'b0;
      IRQ_ERR      <= 1'b0;
    end else if (CE) begin
      IRQ_VALID <= 1'b0;
      case (state_q)
        RDD_IDLE: begin
          if (CMD_REINIT) begin
            CUR_DESC_PTR <= START_PTR;
            first_q      <= 1'b1;
            widx_q       <= '0;
            state_q      <= RDD_FETCH;
          end
        end
        RDD_FETCH: begin
          if (!MEM_REQ) begin
            MEM_REQ  <= 1'b1;
            MEM_WE   <= 1'b0;
            MEM_BE   <= `RDD_BE_ALL;
            MEM_ADDR <= word_addr(CUR_DESC_PTR, widx_q);
          end else if (MEM_ACK) begin
            MEM_REQ <= 1'b0;
            widx_q  <= widx_q + 3'h1;
            if (widx_q == `RDD_FETCH_LAST) begin
              state_q <= RDD_LOADA;
            end
          end
        end
        RDD_LOADA: begin
          if (first_q) begin
            first_addr_q <= CUR_DESC_PTR;
          end
          state_q <= RDD_LOADB;
        end
        RDD_LOADB: begin
          hold_q  <= lnk.dm_rdata[`RDD_HOLD_BIT];
          hi_q    <= lnk.dm_rdata[`RDD_HI_BIT];
          size_q  <= lnk.dm_rdata[`RDD_NO_MSB:`RDD_NO_LSB];
          state_q <= RDD_LOADC;
        end
        RDD_LOADC: begin
          dptr_q    <= lnk.dm_rdata;
          cnt_q     <= '0;
          fe_q      <= 1'b0;
          abort_q   <= 1'b0;
          RXF_READY <= 1'b1;
          state_q   <= RDD_FILL;
        end
        RDD_FILL: begin
          if (rstp_q || CMD_RX_RESET) begin
            RXF_READY <= 1'b0;
            abort_q   <= 1'b1;
            state_q   <= RDD_WSTAT;
          end else if (cnt_q >= size_q) begin
            // Full section: a stop here leaves the frame cut short
            RXF_READY <= 1'b0;
            abort_q   <= stop;
            state_q   <= RDD_WSTAT;
          end else if (take) begin
            RXF_READY <= 1'b0;
            nb_q      <= RXF_NBYTES;
            last_q    <= RXF_LAST;
            MEM_REQ   <= 1'b1;
            MEM_WE    <= 1'b1;
            MEM_ADDR  <= dptr_q + AW'(cnt_q);
            MEM_WDATA <= RXF_DATA;
            MEM_BE    <= lane_en(RXF_NBYTES);
            state_q   <= RDD_WDATA;
          end
        end
        RDD_WDATA: begin
          if (MEM_ACK) begin
            MEM_REQ <= 1'b0;
            cnt_q   <= cnt_q + NW'(nb_q);
            if (last_q) begin
              fe_q    <= 1'b1;
              state_q <= RDD_WSTAT;
            end else begin
              // No ready pulse once the section is full
              RXF_READY <= (cnt_q + NW'(nb_q)) < size_q;
              state_q   <= RDD_FILL;
            end
          end
        end
        RDD_WSTAT: begin
          if (!MEM_REQ) begin
            MEM_REQ   <= 1'b1;
            MEM_WE    <= 1'b1;
            MEM_BE    <= `RDD_BE_ALL;
            MEM_ADDR  <= word_addr(CUR_DESC_PTR, `RDD_W_STAT);
            MEM_WDATA <= stat_word(fe_q, abort_q, cnt_q);
          end else if (MEM_ACK) begin
            MEM_REQ <= 1'b0;
            state_q <= (fe_q || abort_q) ? RDD_WFEP : RDD_BRNCH;
          end
        end
        RDD_WFEP: begin
          if (!MEM_REQ) begin
            MEM_REQ   <= 1'b1;
            MEM_WE    <= 1'b1;
            MEM_BE    <= `RDD_BE_ALL;
            MEM_ADDR  <= word_addr(first_addr_q, `RDD_W_FEP);
            MEM_WDATA <= CUR_DESC_PTR;
          end else if (MEM_ACK) begin
            MEM_REQ <= 1'b0;
            state_q <= RDD_BRNCH;
          end
        end
        RDD_BRNCH: begin
          IRQ_VALID <= hi_q || fe_q || abort_q || stop;
          IRQ_HI    <= hi_q;
          IRQ_FI    <= fe_q || abort_q || stop;
          IRQ_ERR   <= abort_q;
          first_q   <= fe_q || abort_q;
          widx_q    <= '0;
          if (rstp_q) begin
            CUR_DESC_PTR <= START_PTR;
            first_q      <= 1'b1;
            state_q      <= RDD_FETCH;
          end else if (stop) begin
            state_q <= RDD_HALT;
          end else begin
            state_q <= RDD_NEXTP;
          end
        end
        RDD_NEXTP: begin
          CUR_DESC_PTR <= lnk.dm_rdata;
          widx_q       <= '0;
          state_q      <= RDD_FETCH;
        end
        RDD_HALT: begin
          // Only a reinit or a moved last pointer wakes the channel
          if (CMD_REINIT) begin
            CUR_DESC_PTR <= START_PTR;
            first_q      <= 1'b1;
            widx_q       <= '0;
            state_q      <= RDD_FETCH;
          end else if (CHAIN_SEL && LAST_PTR_WR &&
                       LAST_PTR != CUR_DESC_PTR) begin
            state_q <= RDD_NEXTP;
          end
        end
        default: begin
          state_q <= RDD_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RX_ACTIVE          <= 1'b0;
      FRAME_RESULT_BYTE  <= '0;
      FRAME_RESULT_VALID <= 1'b0;
    end else if (CE) begin
      RX_ACTIVE          <= state_q != RDD_IDLE && state_q != RDD_HALT;
      FRAME_RESULT_VALID <= lnk.res_vld;
      if (lnk.res_vld) begin
        FRAME_RESULT_BYTE <= lnk.res_byte;
      end
    end
  end

endmodule
`default_nettype wire

// ==== pkg/rdd_cfg.svh ====
// Constants for the receive descriptor DMA channel
`ifndef RDD_CFG_SVH
`define RDD_CFG_SVH
`define RDD_DESC_WORDS  5
`define RDD_FETCH_LAST  3'h2
`define RDD_W_CTRL      3'h0
`define RDD_W_NEXT      3'h1
`define RDD_W_DATA      3'h2
`define RDD_W_STAT      3'h3
`define RDD_W_FEP       3'h4
`define RDD_WORD_SHIFT  2
`define RDD_HOLD_BIT    30
`define RDD_HI_BIT      29
`define RDD_NO_MSB      28
`define RDD_NO_LSB      16
`define RDD_FE_BIT      31
`define RDD_C_BIT       30
`define RDD_RA_BIT      9
`define RDD_BE_ALL      4'hF
`define RDD_BCAST_A     8'hFE
`define RDD_BCAST_B     8'hFC
`define RDD_HA_ONE      2'b10
`define RDD_HA_TWO      2'b00
`define RDD_HA_BCAST    2'b01
`define RDD_HA_NONE     2'b11
`define RDD_MIN_A16_16  14'h0004
`define RDD_MIN_A16_32  14'h0006
`define RDD_MIN_A8_16   14'h0003
`define RDD_MIN_A8_32   14'h0005
`define RDD_MIN_T0_16   14'h0002
`define RDD_MIN_T0_32   14'h0004
`define RDD_MIN_K_A16   14'h0002
`define RDD_MIN_K_OTH   14'h0001
`endif

// ==== pkg/rdd_pkg.sv ====
// Types of the receive descriptor DMA channel
package rdd_pkg;
  typedef enum logic [3:0] {
    RDD_IDLE  = 4'h0,
    RDD_FETCH = 4'h1,
    RDD_LOADA = 4'h3,
    RDD_LOADB = 4'h2,
    RDD_LOADC = 4'h6,
    RDD_FILL  = 4'h7,
    RDD_WDATA = 4'h5,
    RDD_WSTAT = 4'h4,
    RDD_WFEP  = 4'hC,
    RDD_BRNCH = 4'hD,
    RDD_NEXTP = 4'hF,
    RDD_HALT  = 4'hE
  } rdd_state_t;
  typedef enum logic [1:0] {
    RDD_AM_A16 = 2'h0,
    RDD_AM_A8  = 2'h1,
    RDD_AM_T1  = 2'h2,
    RDD_AM_T0  = 2'h3
  } rdd_amode_t;
endpackage

// ==== pkg/rdd_link_if.sv ====
// Internal carrier between the DMA core, status generator and store
`timescale 1ns/1ps
`default_nettype none
interface rdd_link_if;
  import rdd_pkg::*;
  logic        fr_eof;
  logic [13:0] fr_len;
  logic        fr_bits_ok;
  logic        fr_ovf;
  logic        fr_crc_ok;
  logic        fr_rab;
  logic        fr_cr;
  logic [7:0]  fr_haddr;
  logic [7:0]  fr_laddr;
  logic [7:0]  h1;
  logic [7:0]  h2;
  logic [7:0]  l1;
  logic [7:0]  l2;
  rdd_amode_t  amode;
  logic        auto_sel;
  logic        crc32;
  logic        keep;
  logic [7:0]  res_byte;
  logic        res_vld;
  logic        dm_we;
  logic [2:0]  dm_waddr;
  logic [2:0]  dm_raddr;
  logic [31:0] dm_wdata;
  logic [31:0] dm_rdata;
  modport core (output fr_eof, fr_len, fr_bits_ok, fr_ovf, fr_crc_ok,
    fr_rab, fr_cr, fr_haddr, fr_laddr, h1, h2, l1, l2, amode, auto_sel,
    crc32, keep, dm_we, dm_waddr, dm_raddr, dm_wdata,
    input res_byte, res_vld, dm_rdata);
  modport stat (input fr_eof, fr_len, fr_bits_ok, fr_ovf, fr_crc_ok,
    fr_rab, fr_cr, fr_haddr, fr_laddr, h1, h2, l1, l2, amode, auto_sel,
    crc32, keep, output res_byte, res_vld);
  modport dmem (input dm_we, dm_waddr, dm_raddr, dm_wdata,
    output dm_rdata);
endinterface
`default_nettype wire

// ==== design/rdd_desc_mem.sv ====
// On-chip store for the current descriptor words
`timescale 1ns/1ps
`default_nettype none
`include "rdd_cfg.svh"
module rdd_desc_mem #(
  parameter int DEPTH = `RDD_DESC_WORDS
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  rdd_link_if.dmem  lnk
);
  logic [31:0] mem_q [DEPTH];
  always_ff @(posedge clk) begin
    if (ce && lnk.dm_we) begin
      mem_q[lnk.dm_waddr] <= lnk.dm_wdata;
    end
  end
  // Registered read: one cycle from address to data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lnk.dm_rdata <= '0;
    end else if (ce) begin
      lnk.dm_rdata <= mem_q[lnk.dm_raddr];
    end
  end
endmodule
`default_nettype wire

// ==== design/rdd_frame_stat.sv ====
// Frame result byte generation at end of frame
`timescale 1ns/1ps
`default_nettype none
`include "rdd_cfg.svh"
module rdd_frame_stat (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  rdd_link_if.stat  lnk
);
  import rdd_pkg::*;
  function automatic logic [13:0] min_len(input rdd_amode_t m,
      input logic c32, input logic kp);
    if (kp) begin
      min_len = (m == RDD_AM_A16) ? `RDD_MIN_K_A16 : `RDD_MIN_K_OTH;
    end else begin
      case (m)
        RDD_AM_A16: min_len = c32 ? `RDD_MIN_A16_32 : `RDD_MIN_A16_16;
        RDD_AM_T0:  min_len = c32 ? `RDD_MIN_T0_32 : `RDD_MIN_T0_16;
        default:    min_len = c32 ? `RDD_MIN_A8_32 : `RDD_MIN_A8_16;
      endcase
    end
  endfunction
  logic       trans;
  logic [1:0] ha;
  logic       la;
  logic [7:0] rb;
  always_comb begin
    trans = (lnk.amode == RDD_AM_T1) || (lnk.amode == RDD_AM_T0);
    ha = `RDD_HA_TWO;
    if (lnk.auto_sel && lnk.amode == RDD_AM_A16) begin
      if (lnk.fr_haddr == lnk.h1) begin
        ha = `RDD_HA_ONE;
      end else if (lnk.fr_haddr == lnk.h2) begin
        ha = `RDD_HA_TWO;
      end else if (lnk.fr_haddr == `RDD_BCAST_A ||
                   lnk.fr_haddr == `RDD_BCAST_B) begin
        ha = `RDD_HA_BCAST;
      end else begin
        ha = `RDD_HA_NONE;
      end
    end
    la = !trans && (lnk.fr_laddr == lnk.l1);
    rb = {lnk.fr_bits_ok, lnk.fr_ovf, lnk.fr_crc_ok, lnk.fr_rab, ha,
          lnk.fr_cr && lnk.amode == RDD_AM_A16, la};
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lnk.res_byte <= '0;
      lnk.res_vld  <= 1'b0;
    end else if (ce) begin
      // Too-short frames raise no valid flag; the byte is still loaded
      lnk.res_vld <= lnk.fr_eof &&
        (lnk.fr_len >= min_len(lnk.amode, lnk.crc32, lnk.keep));
      if (lnk.fr_eof) begin
        lnk.res_byte <= rb;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/rdd_mem_model.sv ====
// Shared memory model answering the channel's bus requests
`timescale 1ns/1ps
`default_nettype none
module rdd_mem_model (
  input  wire logic        clk,
  input  wire logic [1:0]  dly,
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  be,
  output var  logic        ack,
  output var  logic [31:0] rdata
);
  logic [31:0] mem [0:63];
  logic [1:0]  cnt_q = 2'h0;
  // Host-built descriptors and sections
  assign ack = req && (cnt_q == dly);
  // Idle lines show the inverse, never a stale word
  assign rdata = ack ? mem[addr[7:2]] : ~mem[addr[7:2]];
  always @(posedge clk) begin
    cnt_q <= (ack || !req) ? 2'h0 : cnt_q + 2'h1;
    for (int i = 0; i < 4; i++) begin
      if (ack && we && be[i]) mem[addr[7:2]][8*i +: 8] <= wdata[8*i +: 8];
    end
  end
endmodule
`default_nettype wire

// ==== tb/rdd_rx_dma_chk.sv ====
// Port assertions for the receive descriptor DMA channel
`timescale 1ns/1ps
`default_nettype none
module rdd_rx_dma_chk #(
  parameter int AW = 32
) (
  input wire logic                CORE_CLK,
  input wire logic                ARST_N,
  input wire logic                MEM_REQ,
  input wire logic                MEM_ACK,
  input wire logic [AW-1:0]       MEM_ADDR,
  input wire logic                IRQ_VALID,
  input wire logic                IRQ_FI,
  input wire logic                IRQ_ERR,
  input wire logic                FR_EOF,
  input wire logic [13:0]         FR_LEN,
  input wire logic                FR_BITS_OK,
  input wire logic                FR_OVF,
  input wire logic                FR_CRC_OK,
  input wire logic                FR_RAB,
  input wire logic [7:0]          FR_HADDR,
  input wire rdd_pkg::rdd_amode_t ADDR_MODE,
  input wire logic                AUTO_ADDR_SEL,
  input wire logic                CRC_KEEP_SEL,
  input wire logic [7:0]          HIGH_ADDR_ONE,
  input wire logic [7:0]          FRAME_RESULT_BYTE,
  input wire logic                FRAME_RESULT_VALID
);
  import rdd_pkg::*;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  req_hold_a: assert property (
    MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR))
    else $error("request dropped or moved before ack");
  req_gap_a: assert property (
    MEM_REQ && MEM_ACK |=> !MEM_REQ)
    else $error("request not released after ack");
  word_align_a: assert property (
    MEM_REQ |-> MEM_ADDR[1:0] == 2'h0)
    else $error("bus address not word aligned");
  res_cause_a: assert property (
    FRAME_RESULT_VALID |-> $past(FR_EOF, 2))
    else $error("result byte without end of frame");
  res_flags_a: assert property (
    FRAME_RESULT_VALID |-> FRAME_RESULT_BYTE[7:4] ==
      $past({FR_BITS_OK, FR_OVF, FR_CRC_OK, FR_RAB}, 2))
    else $error("result flags differ from frame report");
  short_drop_a: assert property (
    FR_EOF && CRC_KEEP_SEL && ADDR_MODE == RDD_AM_A16 && FR_LEN < 14'h0002
      |-> ##2 !FRAME_RESULT_VALID)
    else $error("short frame reported");
  ha_one_a: assert property (
    FRAME_RESULT_VALID && $past(AUTO_ADDR_SEL && ADDR_MODE == RDD_AM_A16
      && FR_HADDR == HIGH_ADDR_ONE, 2) |-> FRAME_RESULT_BYTE[3:2] == 2'b10)
    else $error("first high address not coded 10");
  err_fi_a: assert property (
    IRQ_VALID && IRQ_ERR |-> IRQ_FI)
    else $error("error interrupt without frame indication");
endmodule
bind rdd_rx_dma rdd_rx_dma_chk #(.AW(AW)) chk_u (.*);
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the receive descriptor DMA channel
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rdd_pkg::*;
  // Bench signals share the port names so the instance connects by name
  logic CORE_CLK = 1'b0;
  logic ARST_N, CE, CMD_REINIT, CMD_RX_RESET, CHAIN_SEL, LAST_PTR_WR;
  logic [31:0] START_PTR, LAST_PTR, MEM_ADDR, MEM_WDATA, MEM_RDATA;
  logic [31:0] RXF_DATA, CUR_DESC_PTR;
  logic MEM_REQ, MEM_WE, MEM_ACK, RXF_VALID, RXF_LAST, RXF_READY;
  logic [3:0] MEM_BE;
  logic [2:0] RXF_NBYTES;
  logic IRQ_VALID, IRQ_HI, IRQ_FI, IRQ_ERR, RX_ACTIVE;
  logic FR_EOF, FR_BITS_OK, FR_OVF, FR_CRC_OK, FR_RAB, FR_CR;
  logic [13:0] FR_LEN;
  logic [7:0] FR_HADDR, FR_LADDR, HIGH_ADDR_ONE, HIGH_ADDR_TWO;
  logic [7:0] LOW_ADDR_ONE, LOW_ADDR_TWO, FRAME_RESULT_BYTE;
  logic AUTO_ADDR_SEL, CRC32_SEL, CRC_KEEP_SEL, FRAME_RESULT_VALID;
  rdd_amode_t ADDR_MODE;
  logic [1:0] dly;
  int failures = 0;
  int samples_checked = 0;
  always #4 CORE_CLK = ~CORE_CLK;
  rdd_rx_dma dut_u (.*);
  rdd_mem_model mem_u (.clk(CORE_CLK), .dly(dly), .req(MEM_REQ),
    .we(MEM_WE), .addr(MEM_ADDR), .wdata(MEM_WDATA), .be(MEM_BE),
    .ack(MEM_ACK), .rdata(MEM_RDATA));
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, got);
    samples_checked++;
    if (exp !== got) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic hang(input string what);
    failures++;
    $display("BAD %s expected 1 seen timeout", what);
    test_done();
  endtask
  task automatic ready_wait;
    for (int n = 0; RXF_READY !== 1'b1; n++) begin
      if (n > 200) hang("fifo ready");
      @(negedge CORE_CLK);
    end
  endtask
  task automatic push(input logic [31:0] d, input logic [2:0] nb,
                      input logic l);
    @(posedge CORE_CLK);
    {RXF_VALID, RXF_DATA, RXF_NBYTES, RXF_LAST} <= {1'b1, d, nb, l};
    @(negedge CORE_CLK);
    ready_wait();
    @(posedge CORE_CLK);
    RXF_VALID <= 1'b0;
  endtask
  task automatic wait_irq;
    for (int n = 0; IRQ_VALID !== 1'b1; n++) begin
      if (n > 300) hang("interrupt");
      @(negedge CORE_CLK);
    end
  endtask
  // Descriptor at 0x00 with its section at 0x40, valid before any fetch
  task automatic put_desc(input logic [31:0] w0);
    mem_u.mem[0] = w0;
    mem_u.mem[1] = 32'h0000_0020;
    mem_u.mem[2] = 32'h0000_0040;
    mem_u.mem[3] = 32'h0;
    mem_u.mem[4] = 32'hFFFF_FFFF;
    mem_u.mem[17] = 32'h0;
    @(posedge CORE_CLK);
    CMD_REINIT <= 1'b1;
    @(posedge CORE_CLK);
    CMD_REINIT <= 1'b0;
  endtask
  task automatic t_frame_end;
    dly = 2'h0;
    put_desc(32'h6008_0000);
    push(32'h1122_3344, 3'h4, 1'b0);
    push(32'hAABB_CCDD, 3'h2, 1'b1);
    wait_irq();
    check("status", 32'hC006_0000, mem_u.mem[3]);
    check("end ptr", 32'h0, mem_u.mem[4]);
    check("word", 32'h1122_3344, mem_u.mem[16]);
    check("part", 32'h0000_CCDD, mem_u.mem[17]);
    check("irq", 32'h6, 32'({IRQ_HI, IRQ_FI, IRQ_ERR}));
    repeat (3) @(negedge CORE_CLK);
    check("halt", 32'h0, 32'(RX_ACTIVE));
    $display("test frame_end done");
  endtask
  // Last-pointer chaining: halt on a match, wake on a new last pointer
  task automatic t_chain;
    dly = 2'h1;
    CHAIN_SEL <= 1'b1;
    LAST_PTR  <= 32'h0;
    mem_u.mem[8]  = 32'h0004_0000;
    mem_u.mem[10] = 32'h0000_0040;
    mem_u.mem[11] = 32'h0;
    mem_u.mem[12] = 32'hFFFF_FFFF;
    put_desc(32'h0008_0000);
    push(32'h0102_0304, 3'h4, 1'b1);
    wait_irq();
    check("match", 32'h2, 32'({IRQ_FI, IRQ_ERR}));
    @(posedge CORE_CLK);
    {LAST_PTR, LAST_PTR_WR} <= {32'h0000_0020, 1'b1};
    @(posedge CORE_CLK);
    LAST_PTR_WR <= 1'b0;
    push(32'h0506_0708, 3'h4, 1'b0);
    wait_irq();
    check("cut", 32'h4004_0200, mem_u.mem[11]);
    check("cut end", 32'h20, mem_u.mem[12]);
    check("cut irq", 32'h3, 32'({IRQ_FI, IRQ_ERR}));
    CHAIN_SEL <= 1'b0;
    $display("test chain done");
  endtask
  task automatic t_rx_reset;
    dly = 2'h2;
    put_desc(32'h0008_0000);
    push(32'h5566_7788, 3'h4, 1'b0);
    ready_wait();
    @(posedge CORE_CLK);
    CMD_RX_RESET <= 1'b1;
    @(posedge CORE_CLK);
    CMD_RX_RESET <= 1'b0;
    wait_irq();
    check("abort", 32'h4004_0200, mem_u.mem[3]);
    check("irq", 32'h3, 32'({IRQ_FI, IRQ_ERR}));
    repeat (4) @(negedge CORE_CLK);
    check("restart", 32'h0, CUR_DESC_PTR);
    $display("test rx_reset done");
  endtask
  // Result byte two edges after the report; bit 8 of exp says reported
  task automatic frame(input logic [13:0] len, input logic [3:0] f,
                       input logic [7:0] ha, la, input logic [8:0] exp);
    logic [8:0] got;
    got = 9'h0;
    @(posedge CORE_CLK);
    {FR_EOF, FR_LEN, FR_HADDR, FR_LADDR} <= {1'b1, len, ha, la};
    {FR_BITS_OK, FR_OVF, FR_CRC_OK, FR_RAB} <= f;
    @(posedge CORE_CLK);
    FR_EOF <= 1'b0;
    repeat (3) begin
      @(negedge CORE_CLK);
      if (FRAME_RESULT_VALID === 1'b1) got = {1'b1, FRAME_RESULT_BYTE};
    end
    check("result", 32'(exp), 32'(got));
  endtask
  task automatic t_result;
    frame(14'h6, 4'hA, 8'h11, 8'h33, 9'h1AB);
    frame(14'h6, 4'hA, 8'h22, 8'h44, 9'h1A2);
    frame(14'h6, 4'hA, 8'hFC, 8'h44, 9'h1A6);
    frame(14'h6, 4'h5, 8'hFE, 8'h33, 9'h157);
    frame(14'h3, 4'hA, 8'h11, 8'h33, 9'h000);
    frame(14'h4, 4'hA, 8'h11, 8'h33, 9'h1AB);
    CRC_KEEP_SEL <= 1'b1;
    frame(14'h1, 4'hA, 8'h11, 8'h33, 9'h000);
    frame(14'h2, 4'hA, 8'h11, 8'h33, 9'h1AB);
    CRC_KEEP_SEL <= 1'b0;
    CRC32_SEL    <= 1'b1;
    ADDR_MODE    <= RDD_AM_T0;
    frame(14'h3, 4'hA, 8'h11, 8'h33, 9'h000);
    frame(14'h4, 4'hA, 8'h11, 8'h33, 9'h1A0);
    ADDR_MODE    <= RDD_AM_A8;
    frame(14'h4, 4'hA, 8'h11, 8'h33, 9'h000);
    frame(14'h5, 4'hA, 8'h11, 8'h33, 9'h1A1);
    $display("test result done");
  endtask
  initial begin
    {ARST_N, CMD_REINIT, CMD_RX_RESET, CHAIN_SEL, LAST_PTR_WR} = 5'h0;
    {RXF_VALID, RXF_LAST, FR_EOF, CRC32_SEL, CRC_KEEP_SEL} = 5'h0;
    {CE, AUTO_ADDR_SEL, FR_CR, FR_BITS_OK, FR_OVF, FR_CRC_OK} = 6'h3F;
    {FR_RAB, RXF_NBYTES, FR_LEN} = 18'h0;
    {START_PTR, LAST_PTR, RXF_DATA} = {32'h0, 32'h0000_0080, 32'h0};
    {FR_HADDR, FR_LADDR, HIGH_ADDR_ONE, HIGH_ADDR_TWO} = 32'h0000_1122;
    {LOW_ADDR_ONE, LOW_ADDR_TWO} = 16'h3344;
    ADDR_MODE = RDD_AM_A16;
    dly = 2'h0;
    repeat (12) @(posedge CORE_CLK);
    ARST_N <= 1'b1;
    t_result();
    t_frame_end();
    t_chain();
    t_rx_reset();
    test_done();
  end
endmodule
`default_nettype wire
